// ### src/lsd_sequencer.sv
// Segment display sequencer with Wishbone registers and display RAM
`timescale 1ns/100ps

// How it works
// R1: Duty field picks static, 1/2, 1/3 or 1/4 and commons scan accordingly.
// R2: Driver group field enables only the chosen segment outputs.
// R3: Frame clock field sets display clock source and divide ratio.
// R4: Boost copies common waveforms: all four at static, pairs at half duty.
// R5: RAM bits map to segments by duty, expansion and external-only use.
// R6: Display RAM takes word and byte writes like ordinary memory.
// R7: Once running, RAM is fetched and shown every frame without software.
// R8: Expansion select turns the top four segment pins into the serial link.
// R9: Expansion stream starts at first expansion position, or zero for group 0000.
// R10: Run bit low holds link clocks and alternation low, data frozen.
// R11: Standby floats all expansion pins.
// R12: Each output level comes from data bit and alternation per table.
// R13: With system clock stopped, display halts unless subclock source chosen.
// R14: Software picks a subclock source before low-power modes.
// R15: Software adjusts frame clock select for medium-speed mode.
// R16: Subclock gated in standby; display stops in standby and reset.
// R17: Standby forces the voltage divider off.
// R18: Run bit low halts the block and forces divider off, registers kept.
// R19: Show bit low drives blank data, also on the expansion link.
// R20: At 1/3 duty the frame rate is four thirds of the base rate.
// R21: Alternation toggles once per frame for zero average voltage.
module lsd_sequencer
    import lsd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic standbyMode,
    input wire logic sysClockStopped,
    input wire logic subClockTick,
    output logic [2*COM_PINS-1:0] comLevel,
    output logic [2*SEG_PINS-1:0] segLevel,
    output logic [SEG_PINS-1:0] segDriveEn,
    output logic [COM_PINS-1:0] comDriveEn,
    output logic dividerOn,
    output logic [EXT_PINS-1:0] extPinOut,
    output logic extPinOe
);
    localparam logic [2*SEG_PINS-1:0] SEG_HIGH_MASK = {SEG_PINS{2'b10}};

    logic [7:0] portCtrl;
    logic [7:0] ctrl;
    logic [31:0] ram [RAM_WORDS];
    logic [8:0] sysDiv;
    logic [1:0] subDiv;
    logic [1:0] slotDiv;
    logic [1:0] comIdx;
    logic alt;
    logic running;
    logic baseTick;
    logic slotAdv;
    logic frameWrap;
    logic busReq;
    logic [31:0] readData;
    logic [POSITIONS-1:0] rowBits;
    logic [SEG_PINS-1:0] segData;
    logic [COM_PINS-1:0] comData;
    logic [2*SEG_PINS-1:0] next_segLevel;
    logic [2*COM_PINS-1:0] next_comLevel;
    logic [SEG_PINS-1:0] next_segDriveEn;
    lsd_duty_t duty;
    logic [3:0] groupSel;
    logic [3:0] clkSel;

    assign duty = lsd_duty_t'(portCtrl[PPC_DUTY_HI:PPC_DUTY_LO]);
    assign groupSel = portCtrl[PPC_GRP_HI:0];
    assign clkSel = ctrl[CTL_CKS_HI:0];
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Last common index for a duty setting
    function automatic logic [1:0] lastCom(input lsd_duty_t d);
        case (d)
            DUTY_STATIC: lastCom = 2'h0;
            DUTY_HALF: lastCom = 2'h1;
            DUTY_THIRD: lastCom = 2'h2;
            default: lastCom = 2'h3;
        endcase
    endfunction

    // Low-bit mask whose all-ones pattern marks a divider tick
    function automatic logic [8:0] divMask(input logic [3:0] sel);
        if (sel[3])
            divMask = 9'((10'h002 << sel[2:0]) - 10'h001);
        else if (sel[1])
            divMask = 9'h003;
        else
            divMask = {8'h00, sel[0]};
    endfunction

    // Wishbone answer one cycle after the request
    always_ff @(posedge clk) begin
        if (srst)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= busReq;
    end

    // Control registers; contents survive a cleared run bit
    // R18: registers retained
    always_ff @(posedge clk) begin
        if (srst) begin
            portCtrl <= PPC_RESET;
            ctrl <= CTL_RESET;
        end else if (busReq && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == ADR_PORT_CTRL)
                portCtrl <= wb_dat_i[7:0];
            if (wb_adr_i == ADR_CTRL)
                ctrl <= {1'b1, wb_dat_i[CTL_PWR:0]};
        end
    end

    // R6: byte lanes into display RAM
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int w = 0; w < RAM_WORDS; w++)
                ram[w] <= '0;
        end else if (busReq && wb_we_i && wb_adr_i[7:5] == ADR_RAM_TAG) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b])
                    ram[wb_adr_i[4:2]][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        readData = '0;
        if (wb_adr_i == ADR_PORT_CTRL)
            readData[7:0] = portCtrl;
        else if (wb_adr_i == ADR_CTRL)
            readData[7:0] = ctrl;
        else if (wb_adr_i == ADR_STATUS)
            readData[4:0] = {dividerOn, running, alt, comIdx};
        else if (wb_adr_i[7:5] == ADR_RAM_TAG)
            readData = ram[wb_adr_i[4:2]];
    end

    always_ff @(posedge clk) begin
        if (srst)
            wb_dat_o <= '0;
        else if (busReq && !wb_we_i)
            wb_dat_o <= readData;
    end

    // R16: display stops in standby and in reset
    always_ff @(posedge clk) begin
        if (srst)
            running <= 1'b0;
        else
            running <= ctrl[CTL_RUN] && !standbyMode;
    end

    // R17: divider off in standby or when halted
    always_ff @(posedge clk) begin
        if (srst)
            dividerOn <= 1'b0;
        else
            dividerOn <= ctrl[CTL_PWR] && ctrl[CTL_RUN] && !standbyMode;
    end

    // System clock prescaler; frozen while the system clock is stopped
    always_ff @(posedge clk) begin
        if (srst)
            sysDiv <= '0;
        else if (!sysClockStopped)
            sysDiv <= sysDiv + 9'h001;
    end

    // R16: subclock gated off in standby
    always_ff @(posedge clk) begin
        if (srst)
            subDiv <= '0;
        else if (subClockTick && !standbyMode)
            subDiv <= subDiv + 2'h1;
    end

    // R3: display clock source and ratio
    // R13: system sources give no tick while stopped
    always_comb begin
        if (clkSel[3])
            baseTick = !sysClockStopped && ((sysDiv & divMask(clkSel)) == divMask(clkSel));
        else
            baseTick = subClockTick && !standbyMode
                && (({7'h00, subDiv} & divMask(clkSel)) == divMask(clkSel));
    end

    // R20: slot stretch keeps static and half on the four-slot base
    always_comb begin
        slotAdv = 1'b0;
        if (running && baseTick)
            slotAdv = (slotDiv == (2'h3 >> lastCom(duty))) || duty[1];
        frameWrap = slotAdv && (comIdx == lastCom(duty));
    end

    // R1: common scan
    // R21: alternation flips per frame
    always_ff @(posedge clk) begin
        if (srst || !running) begin
            slotDiv <= '0;
            comIdx <= '0;
            alt <= 1'b0;
        end else if (baseTick) begin
            slotDiv <= slotAdv ? 2'h0 : slotDiv + 2'h1;
            if (frameWrap) begin
                comIdx <= '0;
                alt <= !alt;
            end else if (slotAdv) begin
                comIdx <= comIdx + 2'h1;
            end
        end
    end

    // R5: position p, common c sits at bit 4p+c
    // R19: blank data when show bit is low
    // R7: RAM fetched every slot
    always_comb begin
        for (int p = 0; p < POSITIONS; p++) begin
            rowBits[p] = ctrl[CTL_SHOW]
                && ram[p / POS_PER_WORD][(p % POS_PER_WORD) * BITS_PER_POS + int'(comIdx)];
        end
        segData = rowBits[SEG_PINS-1:0];
    end

    // R4: boost copies common waveforms
    always_comb begin
        for (int c = 0; c < COM_PINS; c++) begin
            if (portCtrl[PPC_BOOST] && duty == DUTY_STATIC)
                comData[c] = 1'b1;
            else if (portCtrl[PPC_BOOST] && duty == DUTY_HALF)
                comData[c] = (2'(c / 2) == comIdx);
            else
                comData[c] = (2'(c) == comIdx);
        end
    end

    // R2: group field enables pins
    // R8: top pins handed to the link
    always_comb begin
        for (int i = 0; i < SEG_PINS; i++) begin
            next_segDriveEn[i] = (i < GROUP_PINS * int'(groupSel))
                && !(portCtrl[PPC_EXT] && i >= SEG_PINS - EXT_PINS);
        end
    end

    // R12: level encoders
    lsd_level_enc #(.N(SEG_PINS), .IS_COM(1'b0)) segEnc (
        .data(segData),
        .alt(alt),
        .duty(duty),
        .level(next_segLevel)
    );

    lsd_level_enc #(.N(COM_PINS), .IS_COM(1'b1)) comEnc (
        .data(comData),
        .alt(alt),
        .duty(duty),
        .level(next_comLevel)
    );

    // Stopped display sits at ground on every pin to keep DC off the panel
    always_ff @(posedge clk) begin
        if (srst || !running) begin
            segLevel <= '0;
            comLevel <= '0;
        end else begin
            segLevel <= next_segLevel;
            comLevel <= next_comLevel;
        end
    end

    // Commons beyond the duty stay disabled unless boosted
    always_ff @(posedge clk) begin
        if (srst) begin
            segDriveEn <= '0;
            comDriveEn <= '0;
        end else begin
            segDriveEn <= next_segDriveEn;
            for (int c = 0; c < COM_PINS; c++)
                comDriveEn[c] <= (2'(c) <= lastCom(duty)) || portCtrl[PPC_BOOST];
        end
    end

    // R9: external-only use starts at position zero
    // Rows longer than a slot are cut short at fast clock settings
    lsd_ext_shifter extLink (
        .clk(clk),
        .srst(srst),
        .enable(portCtrl[PPC_EXT]),
        .running(running),
        .standby(standbyMode),
        .rowStart(slotAdv),
        .rowBits(rowBits),
        .firstPos((groupSel == 4'h0) ? POS_ZERO : EXT_FIRST),
        .alt(alt),
        .pinOut(extPinOut),
        .pinOe(extPinOe)
    );

    // Bus answer is a single cycle pulse
    AST_ACK_PULSE: assert property (@(posedge clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o) else $error("ack held longer than one cycle");

    // R10: halted link
    AST_HALT_LINK: assert property (@(posedge clk) disable iff (srst) // R10
        (!running ##1 !running) |=> (extPinOut[EXT_SHIFT:EXT_LATCH] == 2'h0
            && !extPinOut[EXT_ALT] && $stable(extPinOut[EXT_DATA])))
        else $error("link not held while halted");

    // R17: divider off
    AST_DIV_OFF: assert property (@(posedge clk) disable iff (srst) // R17
        (standbyMode || !ctrl[CTL_RUN]) |=> !dividerOn)
        else $error("divider on while standby or halted");

    // R11: floating pins
    AST_STANDBY_HIZ: assert property (@(posedge clk) disable iff (srst) // R11
        standbyMode |=> !extPinOe) else $error("expansion pins driven in standby");

    // R21: alternation per frame
    AST_ALT_FRAME: assert property (@(posedge clk) disable iff (srst) // R21
        (frameWrap && running) |=> (alt != $past(alt)) && comIdx == 2'h0)
        else $error("alternation did not flip at frame end");

    // R19: blank segments
    AST_BLANK: assert property (@(posedge clk) disable iff (srst) // R19
        (running && !ctrl[CTL_SHOW] && duty[1] && ctrl[CTL_RUN] && !standbyMode)
        |=> (segLevel & SEG_HIGH_MASK) == SEG_HIGH_MASK)
        else $error("segment not blank with show bit low");

    // R4: static boost
    AST_BOOST_STATIC: assert property (@(posedge clk) disable iff (srst) // R4
        (running && portCtrl[PPC_BOOST] && duty == DUTY_STATIC)
        |=> comLevel == {COM_PINS{comLevel[1:0]}} && comDriveEn == {COM_PINS{1'b1}})
        else $error("boosted commons differ at static duty");

    // R13: no scan on a stopped system clock
    AST_STOP_SYS: assert property (@(posedge clk) disable iff (srst) // R13
        (sysClockStopped && clkSel[3] && running) ##1 running
        |-> comIdx == $past(comIdx) && alt == $past(alt))
        else $error("scan moved with system clock stopped");

    // R1: quarter duty wraps after the fourth common
    AST_QUARTER_SCAN: assert property (@(posedge clk) disable iff (srst) // R1
        (slotAdv && duty == DUTY_QUARTER && comIdx == 2'h3 && ctrl[CTL_RUN] && !standbyMode)
        |=> comIdx == 2'h0) else $error("quarter duty scan did not wrap");

    // R2: no on-chip segments for group zero
    AST_GROUP_ZERO: assert property (@(posedge clk) disable iff (srst) // R2
        (groupSel == 4'h0) |=> segDriveEn == '0)
        else $error("segment enabled with group zero");
endmodule

// ### src/lsd_pkg.sv
// Shared constants and types of the segment display sequencer
package lsd_pkg;
    localparam int SEG_PINS = 40;
    localparam int COM_PINS = 4;
    localparam int EXT_PINS = 4;
    localparam int RAM_WORDS = 8;
    localparam int POSITIONS = 64;
    localparam int BITS_PER_POS = 4;
    localparam int POS_PER_WORD = 8;
    localparam int GROUP_PINS = 4;
    localparam logic [5:0] EXT_FIRST = 6'h24;
    localparam logic [5:0] POS_ZERO = 6'h00;

    // Byte addresses on the register bus
    localparam logic [7:0] ADR_PORT_CTRL = 8'h00;
    localparam logic [7:0] ADR_CTRL = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [2:0] ADR_RAM_TAG = 3'h2;

    // panel_port_control_reg fields
    localparam int PPC_BOOST = 7;
    localparam int PPC_EXT = 6;
    localparam int PPC_DUTY_HI = 5;
    localparam int PPC_DUTY_LO = 4;
    localparam int PPC_GRP_HI = 3;
    localparam logic [7:0] PPC_RESET = 8'h00;

    // panel_control_reg fields; bit 7 reads one and is fixed
    localparam int CTL_FIXED = 7;
    localparam int CTL_PWR = 6;
    localparam int CTL_RUN = 5;
    localparam int CTL_SHOW = 4;
    localparam int CTL_CKS_HI = 3;
    localparam logic [7:0] CTL_RESET = 8'h80;

    // Drive level codes
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V1 = 2'h1;
    localparam logic [1:0] LVL_V2 = 2'h2;
    localparam logic [1:0] LVL_V3 = 2'h3;

    // Expansion pin positions
    localparam int EXT_DATA = 0;
    localparam int EXT_LATCH = 1;
    localparam int EXT_SHIFT = 2;
    localparam int EXT_ALT = 3;

    typedef enum logic [1:0] {
        DUTY_STATIC = 2'b00,
        DUTY_HALF = 2'b01,
        DUTY_THIRD = 2'b10,
        DUTY_QUARTER = 2'b11
    } lsd_duty_t;
endpackage

// ### src/lsd_level_enc.sv
// Drive level encoder for a group of common or segment pins
`timescale 1ns/100ps
module lsd_level_enc
    import lsd_pkg::*;
#(
    parameter int N = 4,
    parameter bit IS_COM = 1'b0
) (
    input wire logic [N-1:0] data,
    input wire logic alt,
    input wire lsd_duty_t duty,
    output logic [2*N-1:0] level
);
    // Level from data bit and alternation signal per duty
    function automatic logic [1:0] pick(input logic d, input logic m, input lsd_duty_t dt);
        case (dt)
            DUTY_STATIC: pick = IS_COM ? (m ? LVL_VSS : LVL_V1) : ((d == m) ? LVL_V1 : LVL_VSS);
            DUTY_HALF: begin
                if (IS_COM)
                    pick = d ? (m ? LVL_VSS : LVL_V1) : LVL_V2;
                else
                    pick = (d == m) ? LVL_V1 : LVL_VSS;
            end
            default: begin
                case ({d, m})
                    2'b00: pick = IS_COM ? LVL_V3 : LVL_V2;
                    2'b01: pick = IS_COM ? LVL_V2 : LVL_V3;
                    2'b10: pick = IS_COM ? LVL_V1 : LVL_VSS;
                    default: pick = IS_COM ? LVL_VSS : LVL_V1;
                endcase
            end
        endcase
    endfunction

    // R12: level table
    always_comb begin
        for (int i = 0; i < N; i++) begin
            level[2*i +: 2] = pick(data[i], alt, duty);
        end
    end
endmodule

// ### src/lsd_ext_shifter.sv
// Serial link to the external segment chip: shift, latch, alternation
`timescale 1ns/100ps
module lsd_ext_shifter
    import lsd_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic running,
    input wire logic standby,
    input wire logic rowStart,
    input wire logic [POSITIONS-1:0] rowBits,
    input wire logic [5:0] firstPos,
    input wire logic alt,
    output logic [EXT_PINS-1:0] pinOut,
    output logic pinOe
);
    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_LOW = 2'b01,
        SH_HIGH = 2'b10,
        SH_LATCH = 2'b11
    } lsd_shift_t;

    lsd_shift_t state;
    logic [POSITIONS-1:0] shiftReg;
    logic [6:0] bitsLeft;

    // R11: pins float in standby
    always_ff @(posedge clk) begin
        if (srst)
            pinOe <= 1'b0;
        else
            pinOe <= enable && !standby;
    end

    // R8: data, shift clock, latch clock and alternation
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= SH_IDLE;
            shiftReg <= '0;
            bitsLeft <= '0;
            pinOut <= '0;
        end else if (!running || !enable) begin
            // R10: clocks and alternation low, data frozen
            state <= SH_IDLE;
            pinOut[EXT_LATCH] <= 1'b0;
            pinOut[EXT_SHIFT] <= 1'b0;
            pinOut[EXT_ALT] <= 1'b0;
        end else begin
            pinOut[EXT_ALT] <= alt;
            if (rowStart) begin
                // R9: stream begins at the first expansion position
                shiftReg <= rowBits >> firstPos;
                bitsLeft <= 7'(POSITIONS) - {1'b0, firstPos};
                pinOut[EXT_SHIFT] <= 1'b0;
                pinOut[EXT_LATCH] <= 1'b0;
                state <= SH_LOW;
            end else begin
                case (state)
                    SH_LOW: begin
                        pinOut[EXT_DATA] <= shiftReg[0];
                        pinOut[EXT_SHIFT] <= 1'b0;
                        state <= SH_HIGH;
                    end
                    SH_HIGH: begin
                        pinOut[EXT_SHIFT] <= 1'b1;
                        shiftReg <= shiftReg >> 1;
                        bitsLeft <= bitsLeft - 7'h01;
                        state <= (bitsLeft == 7'h01) ? SH_LATCH : SH_LOW;
                    end
                    SH_LATCH: begin
                        pinOut[EXT_SHIFT] <= 1'b0;
                        pinOut[EXT_LATCH] <= 1'b1;
                        state <= SH_IDLE;
                    end
                    default: begin
                        pinOut[EXT_LATCH] <= 1'b0;
                        state <= SH_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// ### testbench/lsd_seg_chip_model.sv
// Behavioural model of the external segment chip on the expansion link
`timescale 1ns/100ps
module lsd_seg_chip_model
    import lsd_pkg::*;
(
    input wire logic clk,
    input wire logic [EXT_PINS-1:0] pins,
    input wire logic oe,
    output logic [63:0] latched,
    output int lastCount
);
    logic [63:0] shiftReg = 64'h0;
    logic prevShift = 1'b0;
    int count = 0;

    // shift and latch
    // Floating pins are ignored, so a released link never shifts in junk
    always @(posedge clk) begin
        prevShift <= pins[EXT_SHIFT] & oe;
        if (oe && pins[EXT_LATCH]) begin
            latched <= shiftReg;
            lastCount <= count;
            count <= 0;
        end else if (oe && pins[EXT_SHIFT] && !prevShift) begin
            shiftReg <= {shiftReg[62:0], pins[EXT_DATA]};
            count <= count + 1;
        end
    end
endmodule

// ### testbench/lcd_segment_driver_sequencer_test.sv
// Self-checking testbench of the segment display sequencer
`timescale 1ns/100ps
module lcd_segment_driver_sequencer_test;
    import lsd_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic wbAck;
    logic standbyMode = 1'b0;
    logic sysClockStopped = 1'b0;
    logic subClockTick = 1'b0;
    logic [7:0] comLevel;
    logic [79:0] segLevel;
    logic [39:0] segDriveEn;
    logic [3:0] comDriveEn;
    logic dividerOn;
    logic [3:0] extPinOut;
    logic extPinOe;
    logic [63:0] latched;
    int lastCount;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [2:0] tickDiv = 3'h0;
    logic [31:0] rd;
    int cc;
    int ac;

    // Clock, 25 ns period
    always #12.5 clk = ~clk;

    // Subclock enable, one pulse every eight cycles
    always @(posedge clk) begin
        tickDiv <= tickDiv + 3'h1;
        subClockTick <= (tickDiv == 3'h7);
    end

    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            stop_test;
        end
    end

    lsd_sequencer u_dut (.clk(clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .standbyMode(standbyMode),
        .sysClockStopped(sysClockStopped), .subClockTick(subClockTick),
        .comLevel(comLevel), .segLevel(segLevel), .segDriveEn(segDriveEn),
        .comDriveEn(comDriveEn), .dividerOn(dividerOn), .extPinOut(extPinOut),
        .extPinOe(extPinOe));

    lsd_seg_chip_model u_chip (.clk(clk), .pins(extPinOut), .oe(extPinOe),
        .latched(latched), .lastCount(lastCount));

    task stop_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [79:0] got, input logic [79:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One classic cycle; held until ack is sampled, then released
    task wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbSel <= s;
        wbDatW <= d;
        // Only the bench timeout ends a wait for ack
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    // Counts changes of the commons and of the alternation pin
    task watch(input int n);
        logic [7:0] pc;
        logic pa;
        cc = 0;
        ac = 0;
        pc = comLevel;
        pa = extPinOut[EXT_ALT];
        repeat (n) begin
            @(posedge clk);
            if (comLevel !== pc) cc++;
            if (extPinOut[EXT_ALT] !== pa) ac++;
            pc = comLevel;
            pa = extPinOut[EXT_ALT];
        end
    endtask

    task t_reset;
        wb(1'b0, ADR_PORT_CTRL, 4'h1, 32'h0);
        chk(rd, {24'h0, PPC_RESET});
        wb(1'b1, ADR_CTRL, 4'h1, 32'h0);
        wb(1'b0, ADR_CTRL, 4'h1, 32'h0);
        chk(rd, {24'h0, CTL_RESET});
        wb(1'b0, 8'h0C, 4'hF, 32'h0);
        chk(rd, 80'h0);
        chk(dividerOn, 80'h0);
    endtask

    task t_ram;
        wb(1'b1, 8'h40, 4'hF, 32'h12345678);
        wb(1'b1, 8'h40, 4'h4, 32'h00AB0000);
        wb(1'b0, 8'h40, 4'hF, 32'h0);
        chk(rd, 80'h12AB5678);
        for (int i = 0; i < RAM_WORDS; i++)
            wb(1'b1, 8'h40 + 8'(4 * i), 4'hF, 32'hFFFFFFFF);
    endtask

    // Slowest system clock keeps each slot long enough for a whole row
    task t_ext;
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h71);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h7F);
        repeat (3) @(posedge clk);
        chk(extPinOe, 80'h1);
        chk(dividerOn, 80'h1);
        repeat (600) @(posedge clk);
        chk(lastCount, POSITIONS - int'(EXT_FIRST));
        chk(latched[27:0], 80'hFFFFFFF);
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h70);
        repeat (600) @(posedge clk);
        chk(lastCount, POSITIONS);
        chk(segDriveEn, 80'h0);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h6F);
        repeat (600) @(posedge clk);
        chk(latched, 80'h0);
    endtask

    task t_runoff;
        logic d;
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h71);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h7F);
        repeat (300) @(posedge clk);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h5F);
        repeat (2) @(posedge clk);
        d = extPinOut[EXT_DATA];
        repeat (20) @(posedge clk);
        chk(extPinOut, {3'h0, d});
        chk(dividerOn, 80'h0);
        chk(segLevel, 80'h0);
        wb(1'b0, ADR_CTRL, 4'h1, 32'h0);
        chk(rd, 80'hDF);
    endtask

    task t_standby;
        wb(1'b1, ADR_CTRL, 4'h1, 32'h7F);
        repeat (10) @(posedge clk);
        standbyMode <= 1'b1;
        repeat (4) @(posedge clk);
        chk(extPinOe, 80'h0);
        chk(dividerOn, 80'h0);
        chk(segLevel, 80'h0);
        standbyMode <= 1'b0;
    endtask

    task t_level;
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h7F);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h68);
        repeat (8) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            chk(segLevel[1:0] == LVL_V2 || segLevel[1:0] == LVL_V3, 80'h1);
        end
        watch(80);
        chk(ac >= 9 && ac <= 11, 80'h1);
        chk(cc > 0, 80'h1);
        chk(comDriveEn, 80'hF);
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h6F);
        repeat (8) @(posedge clk);
        watch(96);
        chk(ac >= 15 && ac <= 17, 80'h1);
        chk(comDriveEn, 80'h7);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h78);
        repeat (8) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            chk(segLevel[1:0] == LVL_VSS || segLevel[1:0] == LVL_V1, 80'h1);
        end
    endtask

    task t_boost;
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h81);
        repeat (6) @(posedge clk);
        repeat (12) begin
            @(posedge clk);
            chk({comLevel[7:6], comLevel[5:4], comLevel[3:2]}, {3{comLevel[1:0]}});
        end
        chk(comDriveEn, 80'hF);
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h91);
        repeat (6) @(posedge clk);
        repeat (12) begin
            @(posedge clk);
            chk({comLevel[7:6], comLevel[3:2]}, {comLevel[5:4], comLevel[1:0]});
        end
        chk(comDriveEn, 80'hF);
    endtask

    task t_clock;
        wb(1'b1, ADR_PORT_CTRL, 4'h1, 32'h71);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h68);
        sysClockStopped <= 1'b1;
        repeat (4) @(posedge clk);
        watch(40);
        chk(cc, 80'h0);
        wb(1'b1, ADR_CTRL, 4'h1, 32'h60);
        repeat (4) @(posedge clk);
        watch(80);
        chk(cc > 0, 80'h1);
        // Every fourth subclock tick: one slot per 32 cycles
        wb(1'b1, ADR_CTRL, 4'h1, 32'h62);
        repeat (4) @(posedge clk);
        watch(80);
        chk(cc >= 2 && cc <= 3, 80'h1);
        sysClockStopped <= 1'b0;
        wb(1'b1, ADR_CTRL, 4'h1, 32'h68);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_ram;
        t_ext;
        t_runoff;
        t_standby;
        t_level;
        t_boost;
        t_clock;
        stop_test;
    end
endmodule
